/* File: logic/sgp_port.sv */
`timescale 1ns/1ps
`default_nettype none
module sgp_port
  import sgp_pkg::*;
(
  // Clock and fundamental reset
  input wire logic MCLK_I,
  input wire logic RESETN_I,
  // Software configuration
  input wire logic SW_WE_I,
  input wire logic [8:0] SW_DIR_I,
  input wire logic [8:0] SW_OUT_I,
  input wire logic [8:0] SW_ALT_I,
  // Slave SMBus alternate enable write
  input wire logic SMB_ALT_WE_I,
  input wire logic [8:0] SMB_ALT_I,
  // EEPROM alternate enable load
  input wire logic EEP_ALT_WE_I,
  input wire logic [8:0] EEP_ALT_I,
  // Alternate function sources
  input wire logic DOWNSTREAM_A_RESET_I,
  input wire logic DOWNSTREAM_B_RESET_I,
  input wire logic GENERAL_EVENT_I,
  input wire logic EXP_READ_DONE_I,
  // Pins
  input wire logic [8:0] GPIO_I,
  output logic [8:0] GPIO_O,
  output logic [8:0] GPIO_OE_O,
  // Status
  output logic [8:0] PIN_STATE_O,
  output logic [8:0] DIR_STATE_O,
  output logic [8:0] ALT_STATE_O,
  output logic EXPANDER_IRQ_A_O,
  output logic EXPANDER_IRQ_B_O,
  output logic EXP_READ_REQ_O
);
  logic [8:0] pin_sync;
  logic [8:0] dir_q;
  logic [8:0] out_q;
  logic [8:0] alt_raw;
  logic [8:0] alt_q;
  logic [8:0] alt_wdata;
  logic alt_we;
  logic [8:0] alt_val;
  logic [8:0] next_oe;
  logic [8:0] next_out;
  logic irq_a_q;
  logic irq_b_q;

  sgp_sync u_sync (
    .clk_i(MCLK_I),
    .resetn_i(RESETN_I),
    .d_i(GPIO_I),
    .q_o(pin_sync)
  );

  // Software write wins, then SMBus, then EEPROM load
  always_comb begin
    alt_we = SW_WE_I | SMB_ALT_WE_I | EEP_ALT_WE_I; // [R3]
    if (SW_WE_I) begin
      alt_wdata = SW_ALT_I;
    end else if (SMB_ALT_WE_I) begin
      alt_wdata = SMB_ALT_I;
    end else begin
      alt_wdata = EEP_ALT_I;
    end
  end

  sgp_cfg u_alt (
    .clk_i(MCLK_I),
    .resetn_i(RESETN_I),
    .we_i(alt_we),
    .d_i(alt_wdata),
    .rst_val_i(ALT_RESET),
    .q_o(alt_raw)
  );
  assign alt_q = alt_raw & ALT_CAPABLE; // [R13]

  // Direction and output value, cleared by fundamental reset
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin // [R12]
      dir_q <= DIR_RESET;
      out_q <= OUT_RESET;
    end else if (SW_WE_I) begin
      dir_q <= SW_DIR_I; // [R2]
      out_q <= SW_OUT_I;
    end
  end

  // Resets and event drive low when asserted
  always_comb begin
    alt_val = 9'h1ff;
    alt_val[SLOT_RST_A] = ~DOWNSTREAM_A_RESET_I; // [R6] [R4]
    alt_val[SLOT_RST_B] = ~DOWNSTREAM_B_RESET_I; // [R7] [R4]
    alt_val[SLOT_EVENT] = ~GENERAL_EVENT_I; // [R10] [R4]
  end

  // Per-pin mux between software and alternate function
  for (genvar i = 0; i < NPIN; i++) begin : g_pin
    always_comb begin
      if (alt_q[i]) begin // [R14]
        next_oe[i] = ALT_OUTPUT[i];
        next_out[i] = ALT_OUTPUT[i] & alt_val[i];
      end else begin
        next_oe[i] = dir_q[i]; // [R1] [R2]
        next_out[i] = out_q[i];
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      GPIO_O <= OUT_RESET;
      GPIO_OE_O <= DIR_RESET;
    end else begin
      GPIO_O <= next_out;
      GPIO_OE_O <= next_oe;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      PIN_STATE_O <= 9'h000;
      DIR_STATE_O <= DIR_RESET;
      ALT_STATE_O <= ALT_RESET;
    end else begin
      PIN_STATE_O <= pin_sync; // [R5]
      DIR_STATE_O <= next_oe;
      ALT_STATE_O <= alt_q;
    end
  end

  // Interrupt inputs are low active; high means asserted inside
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      irq_a_q <= 1'b0;
      irq_b_q <= 1'b0;
    end else begin
      irq_a_q <= alt_q[SLOT_IRQ_A] & ~pin_sync[SLOT_IRQ_A]; // [R8] [R4]
      irq_b_q <= alt_q[SLOT_IRQ_B] & ~pin_sync[SLOT_IRQ_B]; // [R9] [R4]
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      EXPANDER_IRQ_A_O <= 1'b0;
      EXPANDER_IRQ_B_O <= 1'b0;
    end else begin
      EXPANDER_IRQ_A_O <= irq_a_q;
      EXPANDER_IRQ_B_O <= irq_b_q;
    end
  end

  // Request holds until done; a new assertion edge wins over done
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      EXP_READ_REQ_O <= 1'b0;
    end else if ((irq_a_q & ~EXPANDER_IRQ_A_O) |
                 (irq_b_q & ~EXPANDER_IRQ_B_O)) begin
      EXP_READ_REQ_O <= 1'b1; // [R11]
    end else if (EXP_READ_DONE_I) begin
      EXP_READ_REQ_O <= 1'b0;
    end
  end

  // Assertions
  pin_override_a: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    alt_q[SLOT_RST_A] |=> GPIO_OE_O[SLOT_RST_A]) // [R14]
    else $error("alternate pin 0 not driven");
  rst_a_value_a: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    alt_q[SLOT_RST_A] && DOWNSTREAM_A_RESET_I |=> !GPIO_O[SLOT_RST_A]) // [R6]
    else $error("port 2 reset not low");
  rst_b_value_a: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    alt_q[SLOT_RST_B] && DOWNSTREAM_B_RESET_I |=> !GPIO_O[SLOT_RST_B]) // [R7]
    else $error("port 4 reset not low");
  event_value_a: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    alt_q[SLOT_EVENT] |=> GPIO_O[SLOT_EVENT] == !$past(GENERAL_EVENT_I)) // [R10]
    else $error("event output wrong");
  irq_a_input_a: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    alt_q[SLOT_IRQ_A] |=> !GPIO_OE_O[SLOT_IRQ_A]) // [R8]
    else $error("irq pin 2 driven");
  irq_b_input_a: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    alt_q[SLOT_IRQ_B] |=> !GPIO_OE_O[SLOT_IRQ_B]) // [R9]
    else $error("irq pin 4 driven");
  plain_only_a: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    (ALT_STATE_O & ~ALT_CAPABLE) == 9'h000) // [R13]
    else $error("plain pin has alternate");
  dir_follow_a: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    !alt_q[3] |=> GPIO_OE_O[3] == $past(dir_q[3])) // [R2]
    else $error("pin 3 direction wrong");
  read_req_a: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    irq_a_q && !EXPANDER_IRQ_A_O |=> EXP_READ_REQ_O) // [R11]
    else $error("no expander read");
  alt_write_a: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    SMB_ALT_WE_I && !SW_WE_I |=> alt_raw == $past(SMB_ALT_I)) // [R3]
    else $error("smbus alt write lost");
  reset_clear_a: assert property (@(posedge MCLK_I)
    !RESETN_I |=> GPIO_OE_O == DIR_RESET && !EXP_READ_REQ_O) // [R12]
    else $error("reset not clearing");

  alt_rst_c: cover property (@(posedge MCLK_I) disable iff (!RESETN_I)
    alt_q[SLOT_RST_A] && DOWNSTREAM_A_RESET_I);
  irq_c: cover property (@(posedge MCLK_I) disable iff (!RESETN_I)
    EXP_READ_REQ_O ##1 EXP_READ_DONE_I);
  eep_c: cover property (@(posedge MCLK_I) disable iff (!RESETN_I)
    EEP_ALT_WE_I && !SW_WE_I && !SMB_ALT_WE_I);
  out_c: cover property (@(posedge MCLK_I) disable iff (!RESETN_I)
    GPIO_OE_O[5] && GPIO_O[5]);
endmodule : sgp_port
`default_nettype wire

/* File: inc/sgp_pkg.sv */
// Summary of operation
// (R1) Nine general purpose single-bit pins
// (R2) Each pin has its own direction bit
// (R3) Alternate enable from software, SMBus or EEPROM
// (R4) Names ending _n are active low
// (R5) All other signals are active high; RESETN_I is active low
// (R6) Pin 0 alternate: port 2 reset out
// (R7) Pin 1 alternate: port 4 reset out
// (R8) Pin 2 alternate: expander interrupt 0 input
// (R9) Pin 4 alternate: expander interrupt 2 input
// (R10) Pin 7 alternate: active-low general event out
// (R11) Expander interrupt starts an input read request
// (R12) Fundamental reset clears whole port state; the input synchronizer loads 9'h1ff instead
// (R13) Pins 3,5,6,11 plain I/O only
// (R14) Alternate function overrides direction and value
`default_nettype none
package sgp_pkg;
  localparam int NPIN = 9;
  // Pin slot of each documented pin number
  localparam int SLOT_RST_A = 0;
  localparam int SLOT_RST_B = 1;
  localparam int SLOT_IRQ_A = 2;
  localparam int SLOT_IRQ_B = 4;
  localparam int SLOT_EVENT = 7;
  localparam int SLOT_PIN11 = 8;
  // Slots that own an alternate function
  localparam logic [8:0] ALT_CAPABLE = 9'h097;
  // Slots whose alternate function drives the pin
  localparam logic [8:0] ALT_OUTPUT = 9'h083;
  localparam logic [8:0] DIR_RESET = 9'h000;
  localparam logic [8:0] OUT_RESET = 9'h000;
  localparam logic [8:0] ALT_RESET = 9'h000;
  localparam logic [1:0] SRC_NONE = 2'h0;
endpackage : sgp_pkg
`default_nettype wire

/* File: logic/sgp_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module sgp_sync
  import sgp_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [8:0] d_i,
  output logic [8:0] q_o
);
  logic [8:0] meta;
  // First stage is read only by the second
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      meta <= 9'h1ff;
      q_o <= 9'h1ff;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule : sgp_sync
`default_nettype wire

/* File: logic/sgp_cfg.sv */
`timescale 1ns/1ps
`default_nettype none
module sgp_cfg
  import sgp_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic we_i,
  input wire logic [8:0] d_i,
  input wire logic [8:0] rst_val_i,
  output logic [8:0] q_o
);
  // One written configuration word shared by all writers
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      q_o <= rst_val_i;
    end else if (we_i) begin
      q_o <= d_i;
    end
  end
endmodule : sgp_cfg
`default_nettype wire

/* File: tb/sgp_board.sv */
`timescale 1ns/1ps
`default_nettype none
module sgp_board (
  // Device side
  input wire logic [8:0] gpio_o,
  input wire logic [8:0] gpio_oe,
  // Board drivers
  input wire logic [8:0] ext_val,
  input wire logic [8:0] ext_en,
  // Resolved pins
  output logic [8:0] pin
);
  // Pull-ups: a released active-low line reads negated
  always_comb begin
    for (int i = 0; i < 9; i++) begin
      if (gpio_oe[i]) pin[i] = gpio_o[i];
      else if (ext_en[i]) pin[i] = ext_val[i]; // Irq low
      else pin[i] = 1'b1;
    end
  end
endmodule : sgp_board
`default_nettype wire

/* File: tb/switch_gpio_alt_function_port_test.sv */
`timescale 1ns/1ps
`default_nettype none
module switch_gpio_alt_function_port_test;
  import sgp_pkg::*;
  logic clk = 0;
  logic rstn = 0;
  logic sw_we = 0, smb_we = 0, eep_we = 0, done = 0;
  logic rst_a = 0, rst_b = 0, gev = 0, irq_a, irq_b, req;
  logic [8:0] sw_dir = 0, sw_out = 0, sw_alt = 0, smb_alt = 0, eep_alt = 0;
  logic [8:0] ext_val = 0, ext_en = 0, pin, gpo, gpoe, pst, dst, ast;
  int error_cnt = 0;
  int checks = 0;
  sgp_port dut (.MCLK_I(clk), .RESETN_I(rstn), .SW_WE_I(sw_we),
    .SW_DIR_I(sw_dir), .SW_OUT_I(sw_out), .SW_ALT_I(sw_alt),
    .SMB_ALT_WE_I(smb_we), .SMB_ALT_I(smb_alt), .EEP_ALT_WE_I(eep_we),
    .EEP_ALT_I(eep_alt), .DOWNSTREAM_A_RESET_I(rst_a),
    .DOWNSTREAM_B_RESET_I(rst_b), .GENERAL_EVENT_I(gev),
    .EXP_READ_DONE_I(done), .GPIO_I(pin), .GPIO_O(gpo), .GPIO_OE_O(gpoe),
    .PIN_STATE_O(pst), .DIR_STATE_O(dst), .ALT_STATE_O(ast),
    .EXPANDER_IRQ_A_O(irq_a), .EXPANDER_IRQ_B_O(irq_b),
    .EXP_READ_REQ_O(req));
  sgp_board board (.gpio_o(gpo), .gpio_oe(gpoe), .ext_val(ext_val),
    .ext_en(ext_en), .pin(pin));
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic final_report();
    if (error_cnt == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  task automatic chk(string nm, logic [8:0] exp, logic [8:0] got);
    checks++;
    if (exp !== got) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic settle(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  task automatic sw_cfg(logic [8:0] d, logic [8:0] o, logic [8:0] a);
    @(posedge clk);
    sw_we <= 1;
    sw_dir <= d;
    sw_out <= o;
    sw_alt <= a;
    @(posedge clk);
    sw_we <= 0;
    settle(3);
  endtask : sw_cfg
  task automatic t_reset();
    @(posedge clk);
    rstn <= 0;
    repeat (16) @(posedge clk);
    rstn <= 1;
    settle(1);
    chk("oe", 9'h000, gpoe);
    chk("alt", 9'h000, ast);
  endtask : t_reset
  task automatic t_dir();
    sw_cfg(9'h155, 9'h1f0, 9'h000);
    chk("oe", 9'h155, gpoe);
    chk("dir", 9'h155, dst);
    chk("out", 9'h150, gpo & gpoe);
    ext_en <= 9'h0aa;
    ext_val <= 9'h08a;
    settle(5);
    chk("pins", 9'h1da, pst);
  endtask : t_dir
  task automatic t_alt();
    ext_en <= 9'h000;
    smb_we <= 1;
    smb_alt <= 9'h1ff;
    rst_a <= 1;
    gev <= 1;
    settle(1);
    smb_we <= 0;
    settle(3);
    chk("alt", 9'h097, ast);
    chk("oe", 9'h1c3, gpoe);
    chk("altout", 9'h002, gpo & 9'h083);
    rst_a <= 0;
    rst_b <= 1;
    gev <= 0;
    settle(3);
    chk("altout", 9'h081, gpo & 9'h083);
    eep_we <= 1;
    eep_alt <= 9'h168;
    settle(1);
    eep_we <= 0;
    settle(2);
    chk("alt", 9'h000, ast);
  endtask : t_alt
  task automatic t_irq(logic [8:0] m, logic [8:0] exp);
    int i;
    sw_cfg(9'h000, 9'h000, m);
    ext_val <= 9'h000;
    ext_en <= m;
    for (i = 0; i < 20 && req !== 1'b1; i++) settle(1);
    if (i == 20) begin
      chk("req", 9'h001, {8'h00, req});
      final_report();
    end
    chk("irq", exp, {7'h00, irq_b, irq_a});
    ext_en <= 9'h000;
    done <= 1;
    settle(1);
    done <= 0;
    settle(6);
    chk("req", 9'h000, {8'h00, req});
  endtask : t_irq
  initial begin
    t_reset();
    t_dir();
    t_alt();
    t_irq(9'h004, 9'h001);
    t_irq(9'h010, 9'h002);
    sw_cfg(9'h0ff, 9'h000, 9'h097);
    t_reset();
    final_report();
  end
endmodule : switch_gpio_alt_function_port_test
`default_nettype wire
